// [verilog/imr_pkg.sv]
package imr_pkg;
  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int          MCLK_NS       = 40;
  localparam int          SCL_LOW_NS    = 4700;
  localparam int          SCL_HIGH_NS   = 4000;
  localparam int          TIMER_W       = 8;
  localparam logic [7:0]  LOW_CYC       = 8'((SCL_LOW_NS + MCLK_NS - 1) / MCLK_NS);
  localparam logic [7:0]  HIGH_CYC      = 8'((SCL_HIGH_NS + MCLK_NS - 1) / MCLK_NS);
  localparam logic [11:0] SLV_TIMEOUT_CYC = 12'hfa0;
  // ------------------------------------------------------------------
  // Byte framing and field values
  // ------------------------------------------------------------------
  localparam logic [3:0]  LAST_DATA_BIT = 4'h7;
  localparam logic [3:0]  ACK_BIT       = 4'h8;
  localparam logic        DIR_READ      = 1'b1;
  localparam logic        ACK_LOW       = 1'b0;
  localparam logic        STR_AT_9      = 1'b0;
  localparam logic        STR_AT_8      = 1'b1;
  localparam logic [7:0]  BUF_RESET     = 8'h00;
  localparam int          PIN_W         = 4;
  // Synchronised pin vector layout
  localparam int          PIN_MDATA     = 0;
  localparam int          PIN_MCLK      = 1;
  localparam int          PIN_ADATA     = 2;
  localparam int          PIN_ACLK      = 3;

  typedef enum logic [2:0] {
    RX_IDLE, RX_LOW, RX_HIGH, RX_OVERRUN, RX_STRETCH
  } imr_rx_state_type;

  typedef enum logic [1:0] {
    SL_IDLE, SL_ADDR, SL_ACK
  } imr_slave_state_type;
endpackage

// [verilog/imr_line_if.sv]
`timescale 1ns/1ps
interface imr_line_if;
  logic scl;
  logic sda;
  logic slave_on;
  logic slave_sda_pull;
  logic slave_addr_match;

  modport master (output scl, output sda, output slave_on,
                  input slave_sda_pull, input slave_addr_match);
  modport slave  (input scl, input sda, input slave_on,
                  output slave_sda_pull, output slave_addr_match);
endinterface

// [verilog/imr_sync.sv]
`timescale 1ns/1ps
module imr_sync import imr_pkg::*; (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [PIN_W-1:0] d,
  output logic      [PIN_W-1:0] q
);
  logic [PIN_W-1:0] stage1;

  // Two flops per pin; the first stage feeds only the second
  for (genvar i = 0; i < PIN_W; i++) begin : g_sync
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        stage1[i] <= 1'b1;
        q[i]      <= 1'b1;
      end else begin
        stage1[i] <= d[i];
        q[i]      <= stage1[i];
      end
    end
  end
endmodule // imr_sync

// [verilog/imr_slave_match.sv]
`timescale 1ns/1ps
module imr_slave_match import imr_pkg::*; (
  input  wire logic       mclk,
  input  wire logic       rst,
  imr_line_if.slave       line,
  input  wire logic [6:0] first_slave_address_reg,
  input  wire logic [6:0] second_slave_address_reg,
  input  wire logic       second_address_enable,
  input  wire logic       timeout_protocol_mode_bit
);
  imr_slave_state_type state, next_state;
  logic [7:0]  shift, next_shift;
  logic [3:0]  cnt, next_cnt;
  logic [11:0] low_cnt, next_low_cnt;
  logic        scl_d, sda_d, pull, next_pull, match, next_match;
  logic        scl_rise, scl_fall, start_seen, stop_seen, hit;

  assign scl_rise   = line.scl & ~scl_d;
  assign scl_fall   = ~line.scl & scl_d;
  assign start_seen = line.scl & scl_d & sda_d & ~line.sda;
  assign stop_seen  = line.scl & scl_d & ~sda_d & line.sda;
  assign hit = (shift[7:1] == first_slave_address_reg) |
               (second_address_enable & (shift[7:1] == second_slave_address_reg));
  assign line.slave_sda_pull   = pull;
  assign line.slave_addr_match = match;

  always_comb begin
    next_state   = state;
    next_shift   = shift;
    next_cnt     = cnt;
    next_pull    = pull;
    next_match   = 1'b0;
    next_low_cnt = line.scl ? 12'h000 : low_cnt + 12'h001;
    case (state)
      SL_IDLE: begin
        next_pull = 1'b0;
      end
      SL_ADDR: begin
        if (scl_rise) begin
          next_shift = {shift[6:0], line.sda};
          next_cnt   = cnt + 4'h1;
        end
        if (scl_fall && cnt == ACK_BIT) begin
          next_state = hit ? SL_ACK : SL_IDLE;
          next_pull  = hit;
          next_match = hit;
        end
      end
      SL_ACK: begin
        if (scl_fall) begin
          next_pull  = 1'b0;
          next_state = SL_IDLE;
        end
      end
      default: next_state = SL_IDLE;
    endcase
    if (start_seen) begin
      next_state = SL_ADDR;
      next_cnt   = 4'h0;
      next_pull  = 1'b0;
    end
    // Bus timeout only applies while acting as a slave
    if (stop_seen || (timeout_protocol_mode_bit && low_cnt == SLV_TIMEOUT_CYC)) begin
      next_state = SL_IDLE;
      next_pull  = 1'b0;
    end
    if (!line.slave_on) begin
      next_state   = SL_IDLE;
      next_pull    = 1'b0;
      next_low_cnt = 12'h000;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state   <= SL_IDLE;
      shift   <= 8'h00;
      cnt     <= 4'h0;
      low_cnt <= 12'h000;
      pull    <= 1'b0;
      match   <= 1'b0;
      scl_d   <= 1'b1;
      sda_d   <= 1'b1;
    end else begin
      state   <= next_state;
      shift   <= next_shift;
      cnt     <= next_cnt;
      low_cnt <= next_low_cnt;
      pull    <= next_pull;
      match   <= next_match;
      scl_d   <= line.scl;
      sda_d   <= line.sda;
    end
  end
endmodule // imr_slave_match

// [verilog/imr_rx_master.sv]
// Contract
// - Read-direction address puts controller into receive, self-clocking SCL, sampling SDA.
// - Shift register backs data_buffer so next byte arrives during software handling.
// - Ninth clock carries ack_select_bit on SDA as the acknowledge.
// - Completed byte with empty buffer moves into data_buffer, sets rx_ready_flag.
// - Completed byte with full buffer stays in shift register, sets rx_overrun_flag.
// - Software read of data_buffer returns byte and empties buffer.
// - Pending overrun halts SCL and withholds the acknowledge clock.
// - Only a data_buffer read, or leaving master mode, clears overrun and rx_overrun_flag.
// - After overrun clears, held byte moves in, ready set, SCL resumes after low time.
// - Clocking stops on overrun, stop request before new byte, or stretch.
// - Stretch enabled holds SCL low after 9th clock, or 8th when point is 1.
// - Stretch sets stretch_flag; SCL stays low until software clears it.
// - Stretch after 8th clock keeps ack_select_bit value on SDA until released.
// - Clearing controller_enable_bit resets controller and releases both lines.
// - alt_pin_location_bit routes data and clock to the alternate pins.
// - master_select_bit 0 makes block a slave; timeout mode only there.
// - Slave recognises two addresses; second enabled by second_address_enable.
// - With controller disabled, pins are push-pull general outputs P1.0 and P1.1.
// - ack_select_bit 1 leaves SDA high, 0 pulls SDA low.
// - stretch_point_select ignored and no stretching while stretch_enable_bit is 0.
`timescale 1ns/1ps
module imr_rx_master import imr_pkg::*; (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       controller_enable_bit,
  input  wire logic       master_select_bit,
  input  wire logic       alt_pin_location_bit,
  input  wire logic       address_sent,
  input  wire logic       transfer_direction_bit,
  input  wire logic       ack_select_bit,
  input  wire logic       stop_request_bit,
  input  wire logic       stretch_enable_bit,
  input  wire logic       stretch_point_select,
  input  wire logic       stretch_flag_clear,
  input  wire logic       data_buffer_read,
  output logic      [7:0] data_buffer,
  output logic            rx_ready_flag,
  output logic            rx_overrun_flag,
  output logic            stretch_flag,
  output logic            rx_active,
  input  wire logic       timeout_protocol_mode_bit,
  input  wire logic       second_address_enable,
  input  wire logic [6:0] first_slave_address_reg,
  input  wire logic [6:0] second_slave_address_reg,
  output logic            slave_addr_match,
  input  wire logic [1:0] gpio_port_bits,
  input  wire logic       master_data_pin_in,
  output logic            master_data_pin_out,
  output logic            master_data_pin_oe_n,
  input  wire logic       master_clock_pin_in,
  output logic            master_clock_pin_out,
  output logic            master_clock_pin_oe_n,
  input  wire logic       alt_data_pin_in,
  output logic            alt_data_pin_out,
  output logic            alt_data_pin_oe_n,
  input  wire logic       alt_clock_pin_in,
  output logic            alt_clock_pin_out,
  output logic            alt_clock_pin_oe_n
);
  // ------------------------------------------------------------------
  // Pin sampling and routing
  // ------------------------------------------------------------------
  logic [PIN_W-1:0] pin_sync;
  imr_line_if       line ();

  imr_sync u_sync (
    .mclk (mclk),
    .rst  (rst),
    .d    ({alt_clock_pin_in, alt_data_pin_in, master_clock_pin_in, master_data_pin_in}),
    .q    (pin_sync)
  );

  assign line.scl      = alt_pin_location_bit ? pin_sync[PIN_ACLK]  : pin_sync[PIN_MCLK];
  assign line.sda      = alt_pin_location_bit ? pin_sync[PIN_ADATA] : pin_sync[PIN_MDATA];
  assign line.slave_on = controller_enable_bit & ~master_select_bit;
  assign slave_addr_match = line.slave_addr_match;

  imr_slave_match u_slave (
    .mclk                      (mclk),
    .rst                       (rst),
    .line                      (line.slave),
    .first_slave_address_reg   (first_slave_address_reg),
    .second_slave_address_reg  (second_slave_address_reg),
    .second_address_enable     (second_address_enable),
    .timeout_protocol_mode_bit (timeout_protocol_mode_bit)
  );

  // ------------------------------------------------------------------
  // Receive state
  // ------------------------------------------------------------------
  imr_rx_state_type   state, next_state;
  logic [3:0]         bit_cnt, next_bit_cnt;
  logic [TIMER_W-1:0] timer, next_timer;
  logic [7:0]         shift, next_shift;
  logic [7:0]         next_data_buffer;
  logic               buf_full, next_buf_full;
  logic               next_rx_ready_flag, next_rx_overrun_flag, next_stretch_flag;
  logic               stretch_at8, next_stretch_at8;
  logic               scl_pull, next_scl_pull;
  logic               sda_pull, next_sda_pull;
  logic               master_on, buf_taken, byte_moved, ack_drive;
  logic [7:0]         new_byte;

  assign master_on = controller_enable_bit & master_select_bit;
  assign buf_taken = buf_full & ~data_buffer_read;
  assign new_byte  = {shift[6:0], line.sda};
  assign ack_drive = (ack_select_bit == ACK_LOW);
  assign rx_active = (state != RX_IDLE);

  always_comb begin
    next_state           = state;
    next_bit_cnt         = bit_cnt;
    next_timer           = timer;
    next_shift           = shift;
    next_data_buffer     = data_buffer;
    next_buf_full        = buf_full;
    next_rx_ready_flag   = rx_ready_flag;
    next_rx_overrun_flag = rx_overrun_flag;
    next_stretch_flag    = stretch_flag;
    next_stretch_at8     = stretch_at8;
    next_scl_pull        = scl_pull;
    next_sda_pull        = sda_pull;
    byte_moved           = 1'b0;
    // Clears first so that a same-cycle set below wins
    if (data_buffer_read) begin
      next_buf_full      = 1'b0;
      next_rx_ready_flag = 1'b0;
    end
    if (stretch_flag_clear) begin
      next_stretch_flag = 1'b0;
    end
    case (state)
      RX_IDLE: begin
        next_scl_pull = 1'b0;
        next_sda_pull = 1'b0;
        if (master_on && address_sent && transfer_direction_bit == DIR_READ) begin
          next_state   = RX_LOW;
          next_bit_cnt = 4'h0;
          next_timer   = LOW_CYC;
          next_scl_pull = 1'b1;
        end
      end
      RX_LOW: begin
        next_scl_pull = 1'b1;
        next_sda_pull = (bit_cnt == ACK_BIT) & ack_drive;
        next_timer    = timer - 8'h01;
        if (timer == 8'h01) begin
          next_state    = RX_HIGH;
          next_scl_pull = 1'b0;
          next_timer    = HIGH_CYC;
        end
      end
      RX_HIGH: begin
        // Slave may hold SCL low; high time counts only once it is seen high
        if (line.scl) begin
          next_timer = timer - 8'h01;
          if (timer == 8'h01) begin
            next_scl_pull = 1'b1;
            next_sda_pull = 1'b0;
            next_timer    = LOW_CYC;
            if (bit_cnt == ACK_BIT) begin
              if (stretch_enable_bit && stretch_point_select == STR_AT_9) begin
                next_state        = RX_STRETCH;
                next_stretch_flag = 1'b1;
                next_stretch_at8  = 1'b0;
              end else if (stop_request_bit) begin
                next_state    = RX_IDLE;
                next_scl_pull = 1'b0;
              end else begin
                next_state   = RX_LOW;
                next_bit_cnt = 4'h0;
              end
            end else begin
              next_shift   = new_byte;
              next_bit_cnt = bit_cnt + 4'h1;
              next_state   = RX_LOW;
              if (bit_cnt == LAST_DATA_BIT) begin
                if (buf_taken) begin
                  next_state           = RX_OVERRUN;
                  next_rx_overrun_flag = 1'b1;
                end else begin
                  next_data_buffer   = new_byte;
                  next_buf_full      = 1'b1;
                  next_rx_ready_flag = 1'b1;
                  byte_moved         = 1'b1;
                end
              end
            end
          end
        end
      end
      RX_OVERRUN: begin
        // SCL held and the acknowledge clock withheld
        next_scl_pull = 1'b1;
        next_sda_pull = 1'b0;
        if (data_buffer_read) begin
          next_rx_overrun_flag = 1'b0;
          next_data_buffer     = shift;
          next_buf_full        = 1'b1;
          next_rx_ready_flag   = 1'b1;
          next_timer           = LOW_CYC;
          next_state           = RX_LOW;
          byte_moved           = 1'b1;
        end
      end
      RX_STRETCH: begin
        next_scl_pull = 1'b1;
        next_sda_pull = stretch_at8 & ack_drive;
        if (!stretch_flag) begin
          next_timer = LOW_CYC;
          if (stretch_at8) begin
            next_state = RX_LOW;
          end else if (stop_request_bit) begin
            next_state    = RX_IDLE;
            next_scl_pull = 1'b0;
            next_sda_pull = 1'b0;
          end else begin
            next_state   = RX_LOW;
            next_bit_cnt = 4'h0;
          end
        end
      end
      default: next_state = RX_IDLE;
    endcase
    // A stored byte may hold the line low after the 8th clock
    if (byte_moved && stretch_enable_bit && stretch_point_select == STR_AT_8) begin
      next_state        = RX_STRETCH;
      next_stretch_flag = 1'b1;
      next_stretch_at8  = 1'b1;
      next_sda_pull     = ack_drive;
    end
    // Disabling drops everything and lets go of both lines
    if (!master_on) begin
      next_state           = RX_IDLE;
      next_scl_pull        = 1'b0;
      next_sda_pull        = 1'b0;
      next_bit_cnt         = 4'h0;
      next_stretch_flag    = 1'b0;
      next_rx_overrun_flag = 1'b0;
      next_stretch_at8     = 1'b0;
      if (!controller_enable_bit) begin
        next_buf_full      = 1'b0;
        next_rx_ready_flag = 1'b0;
        next_data_buffer   = BUF_RESET;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state           <= RX_IDLE;
      bit_cnt         <= 4'h0;
      timer           <= 8'h00;
      shift           <= 8'h00;
      data_buffer     <= BUF_RESET;
      buf_full        <= 1'b0;
      rx_ready_flag   <= 1'b0;
      rx_overrun_flag <= 1'b0;
      stretch_flag    <= 1'b0;
      stretch_at8     <= 1'b0;
      scl_pull        <= 1'b0;
      sda_pull        <= 1'b0;
    end else begin
      state           <= next_state;
      bit_cnt         <= next_bit_cnt;
      timer           <= next_timer;
      shift           <= next_shift;
      data_buffer     <= next_data_buffer;
      buf_full        <= next_buf_full;
      rx_ready_flag   <= next_rx_ready_flag;
      rx_overrun_flag <= next_rx_overrun_flag;
      stretch_flag    <= next_stretch_flag;
      stretch_at8     <= next_stretch_at8;
      scl_pull        <= next_scl_pull;
      sda_pull        <= next_sda_pull;
    end
  end

  // ------------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------------
  // Open drain on the bus; push-pull only as general outputs
  logic line_sda_pull;
  assign line_sda_pull = sda_pull | line.slave_sda_pull;

  always_comb begin
    master_data_pin_out   = 1'b0;
    master_clock_pin_out  = 1'b0;
    master_data_pin_oe_n  = 1'b1;
    master_clock_pin_oe_n = 1'b1;
    alt_data_pin_out      = 1'b0;
    alt_clock_pin_out     = 1'b0;
    alt_data_pin_oe_n     = 1'b1;
    alt_clock_pin_oe_n    = 1'b1;
    if (!controller_enable_bit) begin
      master_data_pin_out   = gpio_port_bits[0];
      master_clock_pin_out  = gpio_port_bits[1];
      master_data_pin_oe_n  = 1'b0;
      master_clock_pin_oe_n = 1'b0;
    end else if (alt_pin_location_bit) begin
      alt_data_pin_oe_n  = ~line_sda_pull;
      alt_clock_pin_oe_n = ~scl_pull;
    end else begin
      master_data_pin_oe_n  = ~line_sda_pull;
      master_clock_pin_oe_n = ~scl_pull;
    end
  end
endmodule // imr_rx_master

// [testbench/imr_rx_monitor.sv]
`timescale 1ns/1ps
// ----------
// Receive path checker
// ----------
module imr_rx_monitor (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       controller_enable_bit,
  input wire logic       master_select_bit,
  input wire logic       alt_pin_location_bit,
  input wire logic       address_sent,
  input wire logic       transfer_direction_bit,
  input wire logic       ack_select_bit,
  input wire logic       stretch_enable_bit,
  input wire logic       stretch_point_select,
  input wire logic       stretch_flag_clear,
  input wire logic       data_buffer_read,
  input wire logic [7:0] data_buffer,
  input wire logic       rx_ready_flag,
  input wire logic       rx_overrun_flag,
  input wire logic       stretch_flag,
  input wire logic       rx_active,
  input wire logic [1:0] gpio_port_bits,
  input wire logic       master_data_pin_out,
  input wire logic       master_data_pin_oe_n,
  input wire logic       master_clock_pin_out,
  input wire logic       master_clock_pin_oe_n,
  input wire logic       alt_clock_pin_out,
  input wire logic       alt_clock_pin_oe_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic on, scl_pull, sda_pull;
  assign on = controller_enable_bit && master_select_bit;
  assign scl_pull = alt_pin_location_bit ? !alt_clock_pin_oe_n && !alt_clock_pin_out
                                         : !master_clock_pin_oe_n && !master_clock_pin_out;
  assign sda_pull = !master_data_pin_oe_n && !master_data_pin_out;
  sequence s_start;
    on && address_sent && transfer_direction_bit && !rx_active;
  endsequence
  sequence s_held;
    scl_pull [*8];
  endsequence
  a_start_clocks: assert property (s_start |=> rx_active && scl_pull)
    else $error("receive did not start");
  a_overrun_halt: assert property ($rose(rx_overrun_flag) && on |-> s_held)
    else $error("clock ran during overrun");
  a_overrun_sticky: assert property (rx_overrun_flag && !data_buffer_read && on |=> rx_overrun_flag)
    else $error("overrun cleared without read");
  a_read_resumes: assert property (rx_overrun_flag && data_buffer_read && on
    |=> !rx_overrun_flag && rx_ready_flag) else $error("held byte not moved");
  a_held_byte: assert property (rx_overrun_flag && !data_buffer_read && on |=> $stable(data_buffer))
    else $error("buffer changed in overrun");
  a_no_stretch: assert property (!$past(stretch_enable_bit) |-> !$rose(stretch_flag))
    else $error("stretch while disabled");
  a_stretch_low: assert property (stretch_flag && on |-> scl_pull)
    else $error("clock free during stretch");
  a_stretch_sticky: assert property (stretch_flag && !stretch_flag_clear && on |=> stretch_flag)
    else $error("stretch flag dropped");
  a_ack_held: assert property (stretch_flag && stretch_point_select && on && !alt_pin_location_bit
    |-> sda_pull == !$past(ack_select_bit)) else $error("ack value not held");
  a_gpio_pins: assert property (!controller_enable_bit |-> !master_data_pin_oe_n
    && !master_clock_pin_oe_n && {master_clock_pin_out, master_data_pin_out} == gpio_port_bits)
    else $error("pins not general outputs");
  a_disable_clear: assert property (!controller_enable_bit
    |=> !rx_active && !rx_ready_flag && !rx_overrun_flag && !stretch_flag)
    else $error("disable left state");
  a_alt_route: assert property (alt_pin_location_bit && on
    |-> master_clock_pin_oe_n && master_data_pin_oe_n) else $error("normal pins used");
endmodule // imr_rx_monitor

bind imr_rx_master imr_rx_monitor mon_u (.*);

// [testbench/imr_slave_model.sv]
`timescale 1ns/1ps
// ----------
// Slave transmitter on the bus
// ----------
module imr_slave_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       en,
  input  wire logic [7:0] first_byte,
  output logic            sda_pull,
  output logic            ack_seen
);
  logic [3:0] bit_cnt;
  logic [7:0] cur;
  initial begin
    sda_pull = 1'b0;
    ack_seen = 1'b1;
    bit_cnt = 4'h0;
    cur = 8'h00;
  end
  // Raised after the start fall, so bit 7 sits on the line for the first rise
  always @(posedge en) begin
    bit_cnt = 4'h0;
    cur = first_byte;
    ack_seen = 1'b1;
    sda_pull = ~first_byte[7];
  end
  // Released line goes to the pull-up level
  always @(negedge en) sda_pull = 1'b0;
  always @(negedge scl) begin
    if (en) begin
      if (bit_cnt == 4'h8) begin
        bit_cnt = 4'h0;
        cur = cur + 8'h11;
      end else begin
        bit_cnt = bit_cnt + 4'h1;
      end
      sda_pull = (bit_cnt < 4'h8) ? ~cur[3'(4'h7 - bit_cnt)] : 1'b0;
    end
  end
  always @(posedge scl) begin
    if (en && bit_cnt == 4'h8) ack_seen = sda;
  end
endmodule // imr_slave_model

// [testbench/imr_rx_master_tb.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; $display("ERROR at %0t got %h exp %h", $time, (g), (e)); end end
module imr_rx_master_tb;
  logic       mclk, rst, controller_enable_bit, master_select_bit, alt_pin_location_bit;
  logic       address_sent, transfer_direction_bit, ack_select_bit, stop_request_bit;
  logic       stretch_enable_bit, stretch_point_select, stretch_flag_clear, data_buffer_read;
  logic       timeout_protocol_mode_bit, second_address_enable, slv_en, sda_pull, ack_seen;
  logic [6:0] first_slave_address_reg, second_slave_address_reg;
  logic [1:0] gpio_port_bits;
  logic [7:0] data_buffer;
  logic       rx_ready_flag, rx_overrun_flag, stretch_flag, rx_active, slave_addr_match;
  logic       master_data_pin_out, master_data_pin_oe_n, master_clock_pin_out;
  logic       master_clock_pin_oe_n, alt_data_pin_out, alt_data_pin_oe_n;
  logic       alt_clock_pin_out, alt_clock_pin_oe_n;
  int         n_errors, checks_done;
  // ----------
  // Open-drain wires with pull-ups
  // ----------
  wire master_data_pin_in = (master_data_pin_oe_n | master_data_pin_out)
                            & ~(~alt_pin_location_bit & sda_pull);
  wire master_clock_pin_in = master_clock_pin_oe_n | master_clock_pin_out;
  wire alt_data_pin_in = (alt_data_pin_oe_n | alt_data_pin_out) & ~(alt_pin_location_bit & sda_pull);
  wire alt_clock_pin_in = alt_clock_pin_oe_n | alt_clock_pin_out;
  imr_rx_master dut_u (.*);
  imr_slave_model slv_u (.scl(alt_pin_location_bit ? alt_clock_pin_in : master_clock_pin_in),
    .sda(alt_pin_location_bit ? alt_data_pin_in : master_data_pin_in), .en(slv_en),
    .first_byte(8'ha5), .sda_pull(sda_pull), .ack_seen(ack_seen));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // ----------
  // Helpers
  // ----------
  function automatic logic [7:0] exp_byte(input int k);
    return 8'ha5 + 8'(k * 17);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic wait_for(ref logic s, input logic val, input int lim);
    for (int i = 0; i < lim && s !== val; i++) tick(1);
    `CHK(s, val)
  endtask
  // Slave joins after the start fall, else it counts that edge
  task automatic start_rx();
    slv_en = 1'b0;
    pulse(address_sent);
    tick(2);
    slv_en = 1'b1;
  endtask
  task automatic stop_rx(input int lim);
    stop_request_bit = 1'b1;
    wait_for(rx_active, 1'b0, lim);
    `CHK(master_clock_pin_in, 1'b1)
    stop_request_bit = 1'b0;
    slv_en = 1'b0;
    if (rx_ready_flag === 1'b1) pulse(data_buffer_read);
  endtask
  task automatic final_report();
    if (n_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_basic();
    transfer_direction_bit = 1'b0;
    pulse(address_sent);
    tick(1);
    `CHK(rx_active, 1'b0)
    transfer_direction_bit = 1'b1;
    start_rx();
    wait_for(rx_ready_flag, 1'b1, 3000);
    `CHK(data_buffer, exp_byte(0))
    pulse(data_buffer_read);
    `CHK(rx_ready_flag, 1'b0)
    tick(300);
    ack_select_bit = 1'b1;
    wait_for(rx_ready_flag, 1'b1, 3000);
    `CHK(ack_seen, 1'b0)
    `CHK(data_buffer, exp_byte(1))
    stop_rx(3000);
    `CHK(ack_seen, 1'b1)
    ack_select_bit = 1'b0;
  endtask
  task automatic t_overrun();
    start_rx();
    wait_for(rx_ready_flag, 1'b1, 3000);
    wait_for(rx_overrun_flag, 1'b1, 3000);
    tick(600);
    `CHK(data_buffer, exp_byte(0))
    `CHK(master_clock_pin_in, 1'b0)
    pulse(stretch_flag_clear);
    `CHK(rx_overrun_flag, 1'b1)
    pulse(data_buffer_read);
    `CHK(rx_overrun_flag, 1'b0)
    `CHK(data_buffer, exp_byte(1))
    `CHK(rx_ready_flag, 1'b1)
    tick(60);
    `CHK(master_clock_pin_in, 1'b0)
    stop_rx(600);
    `CHK(ack_seen, 1'b0)
  endtask
  task automatic t_stretch(input logic p);
    stretch_enable_bit = 1'b1;
    stretch_point_select = p;
    start_rx();
    wait_for(stretch_flag, 1'b1, 3000);
    tick(2);
    `CHK(rx_ready_flag, 1'b1)
    if (p) begin
      `CHK(master_data_pin_in, 1'b0)
      ack_select_bit = 1'b1;
      tick(1);
      `CHK(master_data_pin_in, 1'b1)
      ack_select_bit = 1'b0;
    end
    tick(300);
    `CHK(master_clock_pin_in, 1'b0)
    `CHK(stretch_flag, 1'b1)
    stop_request_bit = 1'b1;
    pulse(stretch_flag_clear);
    `CHK(stretch_flag, 1'b0)
    stop_rx(600);
    `CHK(ack_seen, 1'b0)
    stretch_enable_bit = 1'b0;
  endtask
  task automatic t_alt_disable();
    alt_pin_location_bit = 1'b1;
    start_rx();
    wait_for(rx_ready_flag, 1'b1, 3000);
    `CHK(data_buffer, exp_byte(0))
    `CHK(master_clock_pin_oe_n, 1'b1)
    pulse(data_buffer_read);
    tick(200);
    controller_enable_bit = 1'b0;
    tick(1);
    `CHK(rx_active, 1'b0)
    `CHK(alt_clock_pin_in, 1'b1)
    slv_en = 1'b0;
    alt_pin_location_bit = 1'b0;
    // Nine and more clocks with data high free a stuck slave
    for (int i = 0; i < 20; i++) begin
      gpio_port_bits = {~gpio_port_bits[1], 1'b1};
      tick(2);
      `CHK({master_clock_pin_in, master_data_pin_in}, gpio_port_bits)
    end
    controller_enable_bit = 1'b1;
    tick(3);
  endtask
  initial begin
    {rst, controller_enable_bit, alt_pin_location_bit, address_sent} = 4'h8;
    {master_select_bit, transfer_direction_bit, ack_select_bit, stop_request_bit} = 4'hc;
    {stretch_enable_bit, stretch_point_select, stretch_flag_clear, data_buffer_read} = 4'h0;
    {timeout_protocol_mode_bit, second_address_enable, slv_en} = 3'h0;
    first_slave_address_reg = 7'h12;
    second_slave_address_reg = 7'h34;
    gpio_port_bits = 2'h3;
    n_errors = 0;
    checks_done = 0;
    tick(20);
    rst = 1'b0;
    tick(3);
    controller_enable_bit = 1'b1;
    tick(3);
    t_basic();
    t_overrun();
    t_stretch(1'b0);
    t_stretch(1'b1);
    t_alt_disable();
    final_report();
  end
  // Whole run needs about 15000 cycles
  initial begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    final_report();
  end
endmodule // imr_rx_master_tb
